// *** bench/basic_interval_timer16_tb.sv ***
`timescale 1ns/1ns
module basic_interval_timer16_tb;
   import bit_pkg::*;
   typedef struct {logic [31:0] v; bit ne;} bit_note_t;
   // whole run stays far below this many cycles
   localparam int LIMIT = 30000;
   logic              mclk_i = 1'b0;
   logic              nrst_i = 1'b0;
   logic [ADDR_W-1:0] avs_address_i = '0;
   logic              avs_read_i = 1'b0;
   logic              avs_write_i = 1'b0;
   logic [31:0]       avs_writedata_i = '0;
   logic [3:0]        avs_byteenable_i = 4'hF;
   logic [31:0]       avs_readdata_o;
   logic              avs_waitrequest_o;
   logic [2:0]        src = 3'h0;
   logic              idle_i = 1'b0;
   logic              sleep_i = 1'b0;
   logic              irq_o;
   int                error_cnt = 0;
   int                n_compared = 0;
   int                cyc = 0;
   bit_note_t         notes[$];

   // pin index equals the extended select code
   bit_timer #(.CNT_W(16)) bit_timer_inst (
      .mclk_i                (mclk_i),
      .nrst_i                (nrst_i),
      .avs_address_i         (avs_address_i),
      .avs_read_i            (avs_read_i),
      .avs_write_i           (avs_write_i),
      .avs_writedata_i       (avs_writedata_i),
      .avs_byteenable_i      (avs_byteenable_i),
      .avs_readdata_o        (avs_readdata_o),
      .avs_waitrequest_o     (avs_waitrequest_o),
      .secondary_osc_i       (src[0]),
      .low_power_rc_osc_i    (src[2]),
      .external_tick_input_i (src[1]),
      .idle_i                (idle_i),
      .sleep_i               (sleep_i),
      .irq_o                 (irq_o)
   );

   initial forever #4 mclk_i = ~mclk_i;

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // hang guard; counts as a mismatch
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         end_of_test();
      end
   end

   // read data are taken at the edge that sees waitrequest low
   always @(posedge mclk_i) begin
      bit_note_t nt;
      if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
         if (notes.size() == 0) begin
            check("unexpected read", 32'h1, 32'h0);
         end else begin
            nt = notes.pop_front();
            if (nt.ne) begin
               check("count advanced", {31'h0, avs_readdata_o > nt.v}, 1);
            end else begin
               check("read data", avs_readdata_o, nt.v);
            end
         end
      end
   end

   // one access; request held until the edge that sees waitrequest low
   task automatic bus(input logic wr_en, input logic [4:0] a,
                      input logic [15:0] d);
      int w;
      w = 0;
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= {16'h0000, d};
      avs_write_i <= wr_en;
      avs_read_i <= ~wr_en;
      // no cycle budget here: only the hang guard ends a stuck wait
      do begin
         @(posedge mclk_i);
         w++;
      end while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      check("wait cycles", 32'(w - 1), 1);
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] v, input bit ne);
      notes.push_back('{v, ne});
      bus(1'b0, a, 16'h0000);
   endtask

   task automatic wait_irq();
      repeat (2000) begin
         @(negedge mclk_i);
         if (irq_o === 1'b1) break;
      end
   endtask

   // spacing of two events in mclk cycles
   task automatic period_check(input logic [15:0] ctl, input logic [15:0] per,
                               input int exp);
      int t0;
      wr(OFF_CTRL, 16'h0000);
      wr(OFF_COUNT, 16'h0000);
      // run and clocking first, then period, interrupt enable last
      wr(OFF_CTRL, ctl);
      wr(OFF_PERIOD, per);
      wr(OFF_STATUS, 16'h0001);
      wr(OFF_MASK, 16'h0001);
      wait_irq();
      t0 = cyc;
      wr(OFF_STATUS, 16'h0001);
      @(negedge mclk_i);
      check("irq after clear", {31'h0, irq_o}, 0);
      wait_irq();
      check("event spacing", 32'(cyc - t0), exp);
   endtask

   // rising edges on one alternate pin, 2 high and 2 low cycles each
   task automatic pulse(input int p, input int n);
      repeat (n) begin
         @(posedge mclk_i);
         src[p] <= 1'b1;
         repeat (2) @(posedge mclk_i);
         src[p] <= 1'b0;
         @(posedge mclk_i);
      end
      repeat (8) @(posedge mclk_i);
   endtask

   initial begin
      int s;
      int p;
      int n;
      logic [15:0] r;
      void'($urandom(32'h6f99));
      repeat (10) @(posedge mclk_i);
      nrst_i <= 1'b1;
      // reset values and an unmapped word
      rd(OFF_CTRL, 32'h0, 0);
      rd(OFF_PERIOD, 32'hFFFF, 0);
      rd(OFF_COUNT, 32'h0, 0);
      rd(OFF_STATUS, 32'h0, 0);
      rd(OFF_MASK, 32'h0, 0);
      wr(5'h14, 16'hFFFF);
      rd(5'h14, 32'h0, 0);
      wr(OFF_CTRL, 16'hFFFF);
      rd(OFF_CTRL, {16'h0, CTRL_MASK}, 0);
      for (s = 0; s < 6; s++) begin
         r = 16'($urandom);
         wr(OFF_CTRL, r);
         rd(OFF_CTRL, {16'h0, r & CTRL_MASK}, 0);
      end
      // every prescale code, interval = (period+1) x divisor ticks of 2 cycles
      period_check(16'h8000, 16'h0009, 20);
      period_check(16'h8010, 16'h0003, 64);
      period_check(16'h8020, 16'h0001, 256);
      period_check(16'h8030, 16'h0000, 512);
      // period 0 fires every tick: one of two clears meets an event
      wr(OFF_CTRL, 16'h8000);
      wr(OFF_STATUS, 16'h0001);
      wr(OFF_STATUS, 16'h0001);
      rd(OFF_STATUS, 32'h1, 0);
      // sticky status against the mask
      wr(OFF_CTRL, 16'h0000);
      wr(OFF_MASK, 16'h0000);
      @(negedge mclk_i);
      check("masked irq", {31'h0, irq_o}, 0);
      rd(OFF_STATUS, 32'h1, 0);
      wr(OFF_MASK, 16'h0001);
      @(negedge mclk_i);
      check("unmasked irq", {31'h0, irq_o}, 1);
      wr(OFF_STATUS, 16'h0001);
      rd(OFF_STATUS, 32'h0, 0);
      // run bit clear holds the count
      wr(OFF_PERIOD, 16'hFFFF);
      wr(OFF_COUNT, 16'h1234);
      repeat (30) @(posedge mclk_i);
      rd(OFF_COUNT, 32'h1234, 0);
      // idle with and without the halt bit
      idle_i <= 1'b1;
      wr(OFF_CTRL, 16'hA000);
      wr(OFF_COUNT, 16'h0100);
      repeat (20) @(posedge mclk_i);
      rd(OFF_COUNT, 32'h0100, 0);
      wr(OFF_CTRL, 16'h8000);
      repeat (20) @(posedge mclk_i);
      rd(OFF_COUNT, 32'h0100, 1);
      idle_i <= 1'b0;
      // each select code against each pin, synchronised
      for (s = 0; s < 4; s++) begin
         for (p = 0; p < 3; p++) begin
            n = 1 + ($urandom % 8);
            wr(OFF_CTRL, 16'h0000);
            wr(OFF_COUNT, 16'h0000);
            wr(OFF_CTRL, 16'h8006 | 16'(s << 8));
            pulse(p, n);
            rd(OFF_COUNT, (s == p) ? n : 0, 0);
         end
      end
      // sleep keeps only the unsynchronised pin path alive
      sleep_i <= 1'b1;
      for (s = 0; s < 2; s++) begin
         n = 1 + ($urandom % 8);
         wr(OFF_CTRL, 16'h0000);
         wr(OFF_COUNT, 16'h0000);
         wr(OFF_CTRL, 16'h8102 | 16'(s << 2));
         pulse(1, n);
         rd(OFF_COUNT, (s == 0) ? n : 0, 0);
      end
      sleep_i <= 1'b0;
      // gated accumulation on the internal clock
      wr(OFF_CTRL, 16'h0000);
      wr(OFF_COUNT, 16'h0000);
      wr(OFF_STATUS, 16'h0001);
      wr(OFF_CTRL, 16'h8040);
      repeat (20) @(posedge mclk_i);
      rd(OFF_COUNT, 32'h0, 0);
      @(posedge mclk_i);
      src[1] <= 1'b1;
      repeat (40) @(posedge mclk_i);
      src[1] <= 1'b0;
      repeat (10) @(posedge mclk_i);
      rd(OFF_COUNT, 32'd20, 0);
      rd(OFF_STATUS, 32'h1, 0);
      // gate bit ignored once the alternate source is chosen
      wr(OFF_CTRL, 16'h0000);
      wr(OFF_COUNT, 16'h0000);
      wr(OFF_STATUS, 16'h0001);
      wr(OFF_CTRL, 16'h8142);
      n = 1 + ($urandom % 8);
      pulse(1, n);
      rd(OFF_COUNT, n, 0);
      rd(OFF_STATUS, 32'h0, 0);
      repeat (5) @(posedge mclk_i);
      end_of_test();
   end
endmodule

// *** hw/bit_pkg.sv ***
package bit_pkg;

   // register map, one aligned 32-bit word each
   localparam int         ADDR_W     = 5;
   localparam logic [4:0] OFF_CTRL   = 5'h00;
   localparam logic [4:0] OFF_PERIOD = 5'h04;
   localparam logic [4:0] OFF_COUNT  = 5'h08;
   localparam logic [4:0] OFF_STATUS = 5'h0C;
   localparam logic [4:0] OFF_MASK   = 5'h10;

   // control register field positions
   localparam int BIT_RUN       = 15;
   localparam int BIT_IDLE_HALT = 13;
   localparam int EXT_SEL_LO    = 8;
   localparam int BIT_GATE      = 6;
   localparam int PRE_LO        = 4;
   localparam int BIT_SYNC      = 2;
   localparam int BIT_CS        = 1;

   // implemented control bits; all others read zero
   localparam logic [15:0] CTRL_MASK  = 16'hA376;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // period and count reset values
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
   localparam logic [15:0] COUNT_RESET  = 16'h0000;

   // status / mask bit of the single timer event
   localparam int BIT_EVENT = 0;

   // prescaler terminal counts (divisor minus one)
   localparam logic [7:0] PRE_TC_1   = 8'h00;
   localparam logic [7:0] PRE_TC_8   = 8'h07;
   localparam logic [7:0] PRE_TC_64  = 8'h3F;
   localparam logic [7:0] PRE_TC_256 = 8'hFF;

   // instruction clock is half the system clock
   localparam longint CLK_HZ   = 125000000;
   localparam longint INST_HZ  = CLK_HZ / 2;
   localparam int     INST_DIV = int'(CLK_HZ / INST_HZ);
   localparam int     DIV_W    = (INST_DIV > 1) ? $clog2(INST_DIV) : 1;

   // prescaler select codes
   typedef enum logic [1:0] {
      BIT_PRE_1   = 2'b00,
      BIT_PRE_8   = 2'b01,
      BIT_PRE_64  = 2'b10,
      BIT_PRE_256 = 2'b11
   } bit_pre_t;

   // alternate clock source codes
   typedef enum logic [1:0] {
      BIT_SRC_SECONDARY_OSC = 2'b00,
      BIT_SRC_EXT  = 2'b01,
      BIT_SRC_LOW_POWER_RC_OSC = 2'b10,
      BIT_SRC_RSVD = 2'b11
   } bit_ext_t;

endpackage

// *** hw/bit_tick_sync.sv ***
`timescale 1ns/1ns
module bit_tick_sync (
   input  wire logic mclk_i,
   input  wire logic nrst_i,
   input  wire logic raw_i,
   input  wire logic sync_en_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta;
   logic sync2;
   logic direct;
   logic prev;

   // two-flop path; meta is read by sync2 alone
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta  <= 1'b0;
         sync2 <= 1'b0;
      end else begin
         meta  <= raw_i;
         sync2 <= meta;
      end
   end

   // direct path: one stage, shorter latency, no metastability guard
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         direct <= 1'b0;
      end else begin
         direct <= raw_i;
      end
   end

   assign level_o = sync_en_i ? sync2 : direct;

   // edge detect on the chosen level
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev <= 1'b0;
      end else begin
         prev <= level_o;
      end
   end

   assign rise_o = level_o & ~prev;
   assign fall_o = ~level_o & prev;

endmodule

// *** hw/bit_timer.sv ***
`timescale 1ns/1ns
// Behaviour
// - sixteen-bit free-running timer or counter
// - run bit starts and stops counting
// - idle halt bit freezes counting in idle
// - extended select picks alternate clock source
// - extended select only matters when alternate chosen
// - gate enable works only with internal clock
// - prescaler divides by 1, 8, 64, 256
// - sync bit synchronises alternate clock
// - source select: alternate or instruction clock
// - interrupt on match, or gate falling edge
// - counting may continue in idle and sleep
// - unimplemented control bits read zero
module bit_timer #(
   parameter int CNT_W = 16
) (
   input  wire logic                      mclk_i,
   input  wire logic                      nrst_i,
   input  wire logic [bit_pkg::ADDR_W-1:0] avs_address_i,
   input  wire logic                      avs_read_i,
   input  wire logic                      avs_write_i,
   input  wire logic [31:0]               avs_writedata_i,
   input  wire logic [3:0]                avs_byteenable_i,
   output logic      [31:0]               avs_readdata_o,
   output logic                           avs_waitrequest_o,
   input  wire logic                      secondary_osc_i,
   input  wire logic                      low_power_rc_osc_i,
   input  wire logic                      external_tick_input_i,
   input  wire logic                      idle_i,
   input  wire logic                      sleep_i,
   output logic                           irq_o
);
   import bit_pkg::*;

   // counter must fit the 16-bit register lanes
   if (CNT_W < 8 || CNT_W > 16) begin : g_bad_width
      $error("bit_timer: CNT_W must lie in 8..16");
   end

   logic [15:0]      ctrl;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] count;
   logic             irq_status, irq_mask;
   logic             ack;
   logic [DIV_W-1:0] div_cnt;
   logic [7:0]       pre_cnt;
   logic [7:0]       pre_tc;
   logic [2:0]       src_raw;
   logic [2:0]       src_sync;
   logic [2:0]       src_lvl, src_rise, src_fall;
   logic             src_tick, src_en, ptick;
   logic [CNT_W-1:0] next_count;
   logic [15:0]      next_rd16;
   logic             match_evt, gate_evt, event_any;

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      merge16 = {be[1] ? wd[15:8] : old[15:8],
                 be[0] ? wd[7:0]  : old[7:0]};
   endfunction

   // bus request decode
   wire req     = avs_read_i | avs_write_i;
   wire wr_go   = avs_write_i & ack;
   wire hit_ctl = avs_address_i == OFF_CTRL;
   wire hit_per = avs_address_i == OFF_PERIOD;
   wire hit_cnt = avs_address_i == OFF_COUNT;
   wire hit_sts = avs_address_i == OFF_STATUS;
   wire hit_msk = avs_address_i == OFF_MASK;
   wire cnt_wr  = wr_go & hit_cnt;
   wire sts_clr = wr_go & hit_sts & avs_byteenable_i[0]
                  & avs_writedata_i[BIT_EVENT];

   // every access waits exactly one cycle, so data comes from flops
   assign avs_waitrequest_o = req & ~ack;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   // read mux; unmapped addresses answer zero
   always_comb begin
      next_rd16 = 16'h0000;
      if (hit_ctl) begin
         next_rd16 = ctrl & CTRL_MASK;
      end else if (hit_per) begin
         next_rd16[CNT_W-1:0] = period;
      end else if (hit_cnt) begin
         next_rd16[CNT_W-1:0] = count;
      end else if (hit_sts) begin
         next_rd16[BIT_EVENT] = irq_status;
      end else if (hit_msk) begin
         next_rd16[BIT_EVENT] = irq_mask;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && !ack) begin
         avs_readdata_o <= {16'h0000, next_rd16};
      end
   end

   // control: unimplemented bits are never stored
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl <= CTRL_RESET;
      end else if (wr_go && hit_ctl) begin
         ctrl <= merge16(ctrl, avs_writedata_i, avs_byteenable_i)
                 & CTRL_MASK;
      end
   end

   // period register
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         period <= PERIOD_RESET[CNT_W-1:0];
      end else if (wr_go && hit_per) begin
         period <= CNT_W'(merge16(16'(period), avs_writedata_i,
                                  avs_byteenable_i));
      end
   end

   // control register fields
   wire      run       = ctrl[BIT_RUN];
   wire      idle_halt = ctrl[BIT_IDLE_HALT];
   wire      gate_en   = ctrl[BIT_GATE];
   wire      ext_sync  = ctrl[BIT_SYNC];
   wire      alt_sel   = ctrl[BIT_CS];
   bit_ext_t ext_sel;
   bit_pre_t pre_sel;
   assign ext_sel = bit_ext_t'(ctrl[EXT_SEL_LO +: 2]);
   assign pre_sel = bit_pre_t'(ctrl[PRE_LO +: 2]);

   // gate only counts with the internal clock
   wire gate_mode = gate_en & ~alt_sel;
   // stopped, or frozen by idle when asked
   wire halted    = ~run | (idle_i & idle_halt);

   // instruction clock enable, one pulse per INST_DIV cycles
   wire inst_tick = div_cnt == DIV_W'(INST_DIV - 1);

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_cnt <= '0;
      end else if (inst_tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + DIV_W'(1);
      end
   end

   // pins: index 0 secondary osc, 1 tick pin, 2 low-power rc
   assign src_raw = {low_power_rc_osc_i, external_tick_input_i,
                     secondary_osc_i};
   // gate pin is always synchronised; sync bit matters only on alt
   assign src_sync = {ext_sync, ext_sync | ~alt_sel, ext_sync};

   for (genvar i = 0; i < 3; i++) begin : g_src
      bit_tick_sync bit_tick_sync_inst (
         .mclk_i    (mclk_i),
         .nrst_i    (nrst_i),
         .raw_i     (src_raw[i]),
         .sync_en_i (src_sync[i]),
         .level_o   (src_lvl[i]),
         .rise_o    (src_rise[i]),
         .fall_o    (src_fall[i])
      );
   end

   // source mux; sleep stops internal and synchronised alternate counting
   always_comb begin
      src_tick = 1'b0;
      if (!alt_sel) begin
         // gate pin level qualifies the internal ticks
         src_tick = inst_tick & ~sleep_i
                    & (~gate_mode | src_lvl[1]);
      end else begin
         // extended select applies only here
         unique case (ext_sel)
            BIT_SRC_SECONDARY_OSC: src_tick = src_rise[0];
            BIT_SRC_EXT:  src_tick = src_rise[1];
            BIT_SRC_LOW_POWER_RC_OSC: src_tick = src_rise[2];
            BIT_SRC_RSVD: src_tick = 1'b0;
         endcase
         // unsynchronised alternate clock keeps running in sleep
         if (sleep_i && ext_sync) begin
            src_tick = 1'b0;
         end
      end
   end

   assign src_en = src_tick & ~halted;

   // prescaler terminal count per select code
   always_comb begin
      unique case (pre_sel)
         BIT_PRE_1:   pre_tc = PRE_TC_1;
         BIT_PRE_8:   pre_tc = PRE_TC_8;
         BIT_PRE_64:  pre_tc = PRE_TC_64;
         BIT_PRE_256: pre_tc = PRE_TC_256;
      endcase
   end

   assign ptick = src_en & (pre_cnt >= pre_tc);

   // prescaler restarts whenever the timer is stopped
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pre_cnt <= 8'h00;
      end else if (!run) begin
         pre_cnt <= 8'h00;
      end else if (ptick) begin
         pre_cnt <= 8'h00;
      end else if (src_en) begin
         pre_cnt <= pre_cnt + 8'h01;
      end
   end

   // at the period value the next tick returns to zero
   assign next_count = (count == period) ? '0
                       : count + CNT_W'(1);

   // software write wins over a tick in the same cycle
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count <= COUNT_RESET[CNT_W-1:0];
      end else if (cnt_wr) begin
         count <= CNT_W'(merge16(16'(count), avs_writedata_i,
                                 avs_byteenable_i));
      end else if (ptick) begin
         count <= next_count;
      end
   end

   // events: period match, or gate fall in gated mode
   assign match_evt = ptick & ~gate_mode & (next_count == period);
   assign gate_evt  = gate_mode & run & src_fall[1];
   assign event_any = match_evt | gate_evt;

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_status <= 1'b0;
      end else if (event_any) begin
         irq_status <= 1'b1;
      end else if (sts_clr) begin
         irq_status <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_mask <= 1'b0;
      end else if (wr_go && hit_msk && avs_byteenable_i[0]) begin
         irq_mask <= avs_writedata_i[BIT_EVENT];
      end
   end

   assign irq_o = irq_status & irq_mask;

   // checks: one clock domain, reset disables them
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   logic [8:0] gap;
   bit_pre_t   pre_prev;
   logic       sel_moved;
   // source ticks since the last prescaled tick; a tick that follows a
   // prescale change is skipped, its divisor being mixed
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gap       <= 9'h000;
         sel_moved <= 1'b0;
         pre_prev  <= BIT_PRE_1;
      end else begin
         pre_prev  <= pre_sel;
         gap       <= (!run || ptick) ? 9'h000 : gap + 9'(src_en);
         sel_moved <= run && !ptick && (sel_moved || pre_sel != pre_prev);
      end
   end

   sequence s_at_period;
      ptick && count == period && !cnt_wr;
   endsequence

   sequence s_evt_and_clear;
      event_any && sts_clr;
   endsequence

   bus_answer_a: assert property (
      (req && avs_waitrequest_o) |=> (!avs_waitrequest_o || !req))
      else $error("bus request not answered in one cycle");
   run_stop_a: assert property (
      (!run && !cnt_wr) |=> $stable(count))
      else $error("count moved while stopped");
   idle_freeze_a: assert property (
      (idle_i && idle_halt && !cnt_wr) |=> $stable(count))
      else $error("count moved in idle with halt set");
   ext_reserved_a: assert property (
      (alt_sel && ext_sel == BIT_SRC_RSVD) |-> !src_tick)
      else $error("reserved source produced a tick");
   int_clock_a: assert property (
      (!alt_sel && !inst_tick) |-> !src_tick)
      else $error("internal mode ticked off the instruction clock");
   gate_hold_a: assert property (
      (gate_mode && !src_lvl[1] && !cnt_wr) |=> $stable(count))
      else $error("gated count moved with gate low");
   prescale_gap_a: assert property (
      (ptick && !sel_moved && pre_sel == pre_prev)
         |-> gap == {1'b0, pre_tc})
      else $error("prescaled tick at wrong divide");
   wrap_zero_a: assert property (
      s_at_period |=> count == '0)
      else $error("counter did not wrap to zero");
   event_irq_a: assert property (
      event_any |=> irq_status ##0 (irq_o == irq_mask))
      else $error("event did not set status");
   set_wins_a: assert property (
      s_evt_and_clear |=> irq_status)
      else $error("clear beat a same-cycle event");
   ctrl_zero_a: assert property (
      (ctrl & ~CTRL_MASK) == 16'h0000)
      else $error("unimplemented control bit stored");

endmodule
